/* bfo_chk.sv */
// Checker on the ports of the backlight fault and output block
`timescale 1ns/1ns
module bfo_chk (
   input wire       CLK_SYS, SRST, REG_WR, REG_RD, BOOST_EN, THERMAL_COOLED,
   input wire       OVERVOLTAGE_DET, OVERCURRENT_DET, THERMAL_HOT, SUPPLY_LOW_DET,
   input wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
   input wire [1:0] NV_SUPPLY_LOW_SEL, SUPPLY_LOW_THRESH_SEL,
   input wire [5:0] DIM_PWM, PHASE_SHIFT_EN, LED_OUT, STRING_ON
);
   wire rf  = REG_RD && REG_ADDR == 8'h02;
   wire hit = OVERVOLTAGE_DET | OVERCURRENT_DET | THERMAL_HOT | SUPPLY_LOW_DET;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   a_nv_thresh: assert property (SUPPLY_LOW_THRESH_SEL == NV_SUPPLY_LOW_SEL)
      else $error("threshold select differs");
   a_hot_flag: assert property (rf && $past(THERMAL_HOT, 3) |=> REG_RDATA[1])
      else $error("thermal flag missing");
   a_hot_hold: assert property (THERMAL_HOT [*4] ##1 (!THERMAL_COOLED) [*4] |=> !BOOST_EN)
      else $error("outputs back on before recovery");
   a_low_off: assert property (SUPPLY_LOW_DET [*4] |=> !BOOST_EN && STRING_ON == 6'h00)
      else $error("outputs on during supply low");
   a_rd_clear: assert property (rf && !hit && !$past(hit) && !$past(hit, 2) ##1 !hit
      ##1 rf && !hit |=> REG_RDATA == 8'h00) else $error("flags not cleared by read");
   a_rd_upper: assert property (rf |=> REG_RDATA[7:4] == 4'h0)
      else $error("fault status upper bits set");
   a_wr_rdback: assert property (REG_WR && REG_ADDR == 8'h16 ##2 REG_RD && REG_ADDR == 8'h16
      |=> REG_RDATA == {2'h0, $past(REG_WDATA[5:0], 3)}) else $error("string enable readback");
   a_led_force: assert property (BOOST_EN |-> (LED_OUT & $past(DIM_PWM)) == $past(DIM_PWM))
      else $error("dimming lost on output");
   a_string_and: assert property ((STRING_ON & ~$past(PHASE_SHIFT_EN)) == 6'h00)
      else $error("string on without phase enable");
endmodule
bind bfo_fault_ctrl bfo_chk u_chk (.*);

/* bfo_fault_ctrl.v */
// Fault status, direct output force and string enable registers of the backlight driver
//
// Contract
// - Thermal flag bit 1 sets when the monitor reports upper threshold reached.
// - After thermal fault, boost and outputs stay off until recovery threshold crossed.
// - Supply-low flag bit 0 sets; boost and outputs off until supply recovers.
// - Undervoltage threshold select comes from nonvolatile configuration, not a register.
// - Reading fault status at 02h clears bits 3, 2, 1 and 0.
// - Direct output force register at 04h resets to all zeros.
// - String enable register at 16h resets to 0011 1111b.
// - String enable bits 5:0 ANDed with phase-shift logic enables for strings 6:1.
`timescale 1ns/1ns
`include "bfo_regs.vh"
module bfo_fault_ctrl (
   // Clock and reset
   input  wire       CLK_SYS,
   input  wire       SRST,
   // Register port from the serial bus engine
   input  wire [7:0] REG_ADDR,
   input  wire [7:0] REG_WDATA,
   input  wire       REG_WR,
   input  wire       REG_RD,
   output reg  [7:0] REG_RDATA,
   // Analog monitor levels, asynchronous
   input  wire       OVERVOLTAGE_DET,
   input  wire       OVERCURRENT_DET,
   input  wire       THERMAL_HOT,
   input  wire       THERMAL_COOLED,
   input  wire       SUPPLY_LOW_DET,
   // Nonvolatile configuration
   input  wire [1:0] NV_SUPPLY_LOW_SEL,
   output wire [1:0] SUPPLY_LOW_THRESH_SEL,
   // Dimming and phase-shift inputs
   input  wire [5:0] DIM_PWM,
   input  wire [5:0] PHASE_SHIFT_EN,
   // Outputs to power stage
   output reg  [5:0] LED_OUT,
   output reg  [5:0] STRING_ON,
   output reg        BOOST_EN
);
   // ----------------------------------------------------------------
   // Monitor synchronisation
   // ----------------------------------------------------------------
   wire [4:0] mon_sync;
   wire       ov_s;
   wire       oc_s;
   wire       hot_s;
   wire       cool_s;
   wire       uv_s;

   bfo_sync2 #(.W(5)) u_sync (
      .CLK_SYS (CLK_SYS),
      .SRST    (SRST),
      .D       ({SUPPLY_LOW_DET, THERMAL_COOLED, THERMAL_HOT, OVERCURRENT_DET,
                 OVERVOLTAGE_DET}),
      .Q       (mon_sync)
   );

   assign ov_s   = mon_sync[0];
   assign oc_s   = mon_sync[1];
   assign hot_s  = mon_sync[2];
   assign cool_s = mon_sync[3];
   assign uv_s   = mon_sync[4];

   // Threshold choice is wired straight from nonvolatile bits; no register can alter it
   assign SUPPLY_LOW_THRESH_SEL = NV_SUPPLY_LOW_SEL;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [3:0] fault_status_ff;
   reg  [3:0] nxt_fault_status;
   reg  [5:0] direct_output_force_ff;
   reg  [5:0] string_on_bits_ff;
   reg        thermal_hold_ff;
   reg        nxt_thermal_hold;
   wire       rd_status;
   wire [3:0] fault_events;
   wire       shutdown;

   assign rd_status = REG_RD && (REG_ADDR == `BFO_ADDR_FAULT_STATUS);

   assign fault_events[`BFO_BIT_SUPPLY_LOW]  = uv_s;
   assign fault_events[`BFO_BIT_THERMAL]     = hot_s;
   assign fault_events[`BFO_BIT_OVERCURRENT] = oc_s;
   assign fault_events[`BFO_BIT_OVERVOLTAGE] = ov_s;

   // Clear on read, but an event present in the read cycle survives it
   always @* begin
      nxt_fault_status = fault_status_ff;
      if (rd_status) begin
         nxt_fault_status = 4'h0;
      end
      nxt_fault_status = nxt_fault_status | fault_events;
   end

   // Thermal shutdown holds until the cool monitor reports recovery (hysteresis)
   always @* begin
      nxt_thermal_hold = thermal_hold_ff;
      if (hot_s) begin
         nxt_thermal_hold = 1'b1;
      end else if (cool_s) begin
         nxt_thermal_hold = 1'b0;
      end
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         fault_status_ff        <= 4'h0;
         thermal_hold_ff        <= 1'b0;
         direct_output_force_ff <= `BFO_RST_DIRECT_FORCE;
         string_on_bits_ff      <= `BFO_RST_STRING_ENABLE;
      end else begin
         fault_status_ff <= nxt_fault_status;
         thermal_hold_ff <= nxt_thermal_hold;
         if (REG_WR && (REG_ADDR == `BFO_ADDR_DIRECT_FORCE)) begin
            direct_output_force_ff <= REG_WDATA[5:0];
         end
         if (REG_WR && (REG_ADDR == `BFO_ADDR_STRING_ENABLE)) begin
            string_on_bits_ff <= REG_WDATA[5:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data, registered one cycle after the read strobe
   // ----------------------------------------------------------------
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `BFO_ADDR_FAULT_STATUS:  REG_RDATA <= {4'h0, fault_status_ff};
            `BFO_ADDR_DIRECT_FORCE:  REG_RDATA <= {2'h0, direct_output_force_ff};
            `BFO_ADDR_STRING_ENABLE: REG_RDATA <= {2'h0, string_on_bits_ff};
            default:                 REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output gating
   // ----------------------------------------------------------------
   // Live undervoltage level gates, not the sticky flag, so reading never re-enables early
   assign shutdown = thermal_hold_ff | uv_s;

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         LED_OUT   <= 6'h00;
         STRING_ON <= 6'h00;
         BOOST_EN  <= 1'b0;
      end else if (shutdown) begin
         LED_OUT   <= 6'h00;
         STRING_ON <= 6'h00;
         BOOST_EN  <= 1'b0;
      end else begin
         LED_OUT   <= direct_output_force_ff | DIM_PWM;
         STRING_ON <= string_on_bits_ff & PHASE_SHIFT_EN;
         BOOST_EN  <= 1'b1;
      end
   end
endmodule

/* bfo_fault_ctrl_bench.sv */
// Self-checking bench for the backlight fault and output block
`timescale 1ns/1ns
module bfo_fault_ctrl_bench;
   reg        CLK_SYS = 1'b0, SRST = 1'b1, THERMAL_COOLED = 1'b1;
   reg        OVERVOLTAGE_DET = 1'b0, OVERCURRENT_DET = 1'b0, THERMAL_HOT = 1'b0;
   reg        SUPPLY_LOW_DET = 1'b0;
   reg  [1:0] NV_SUPPLY_LOW_SEL = 2'h2;
   reg  [5:0] DIM_PWM = 6'h00, PHASE_SHIFT_EN = 6'h3f;
   reg  [7:0] d;
   wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   wire       REG_WR, REG_RD, BOOST_EN;
   wire [1:0] SUPPLY_LOW_THRESH_SEL;
   wire [5:0] LED_OUT, STRING_ON;
   integer    fail_count = 0, total_checks = 0, i;
   always #25 CLK_SYS = ~CLK_SYS;
   bfo_host HOST (.*);
   bfo_fault_ctrl DUT (.*);
   task chk(input [7:0] g, input [7:0] e);
      total_checks = total_checks + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task rdchk(input [7:0] a, input [7:0] e);
      HOST.rd(a, d);
      chk(d, e);
   endtask
   task t_reset;
      rdchk(8'h04, 8'h00);
      rdchk(8'h16, 8'h3f);
      rdchk(8'h02, 8'h00);
      rdchk(8'h55, 8'h00);
      chk(SUPPLY_LOW_THRESH_SEL, 8'h02);
   endtask
   task t_force;
      DIM_PWM = 6'h01;
      HOST.wr(8'h04, 8'hea);
      HOST.wr(8'h16, 8'h15);
      rdchk(8'h16, 8'h15);
      PHASE_SHIFT_EN = 6'h0f;
      repeat (3) @(negedge CLK_SYS);
      chk(LED_OUT, 8'h2b);
      chk(STRING_ON, 8'h05);
      rdchk(8'h04, 8'h2a);
      HOST.wr(8'h02, 8'hff);
      rdchk(8'h02, 8'h00);
   endtask
   task t_faults;
      for (i = 0; i < 4; i = i + 1) begin
         {OVERVOLTAGE_DET, OVERCURRENT_DET, THERMAL_HOT, SUPPLY_LOW_DET} = 4'h1 << i;
         THERMAL_COOLED = (i != 1);
         repeat (5) @(negedge CLK_SYS);
         chk(BOOST_EN, i > 1);
         chk(LED_OUT, (i > 1) ? 8'h2b : 8'h00);
         chk(STRING_ON, (i > 1) ? 8'h05 : 8'h00);
         rdchk(8'h02, 8'h01 << i);
         {OVERVOLTAGE_DET, OVERCURRENT_DET, THERMAL_HOT, SUPPLY_LOW_DET} = 4'h0;
         repeat (5) @(negedge CLK_SYS);
         chk(BOOST_EN, i != 1);
         THERMAL_COOLED = 1'b1;
         repeat (5) @(negedge CLK_SYS);
         chk(BOOST_EN, 8'h01);
         chk(LED_OUT, 8'h2b);
         rdchk(8'h02, 8'h01 << i);
         rdchk(8'h02, 8'h00);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge CLK_SYS);
      SRST = 1'b0;
      t_reset;
      t_force;
      t_faults;
      end_sim;
   end
   initial begin
      #200000;
      fail_count = fail_count + 1;
      end_sim;
   end
endmodule

/* bfo_host.sv */
// Host model on the block's register strobe port
`timescale 1ns/1ns
module bfo_host (
   input  wire       CLK_SYS,
   input  wire [7:0] REG_RDATA,
   output reg  [7:0] REG_ADDR, REG_WDATA,
   output reg        REG_WR, REG_RD
);
   initial {REG_ADDR, REG_WDATA, REG_WR, REG_RD} = 18'h0;
   // Idle lines show the inverse so a stale sample cannot pass
   task wr(input [7:0] a, input [7:0] v);
      @(negedge CLK_SYS) {REG_ADDR, REG_WDATA, REG_WR} = {a, v, 1'b1};
      @(negedge CLK_SYS) {REG_ADDR, REG_WDATA, REG_WR} = {~a, ~v, 1'b0};
   endtask
   task rd(input [7:0] a, output [7:0] v);
      @(negedge CLK_SYS) {REG_ADDR, REG_RD} = {a, 1'b1};
      @(negedge CLK_SYS) {REG_ADDR, REG_RD} = {~a, 1'b0};
      v = REG_RDATA;
   endtask
endmodule

/* bfo_regs.vh */
// Register map, field positions, reset values and fault encodings for the backlight fault block
`ifndef BFO_REGS_VH
`define BFO_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BFO_ADDR_FAULT_STATUS   8'h02
`define BFO_ADDR_DIRECT_FORCE   8'h04
`define BFO_ADDR_STRING_ENABLE  8'h16

// ----------------------------------------------------------------
// Fault status bit positions
// ----------------------------------------------------------------
`define BFO_BIT_SUPPLY_LOW      0
`define BFO_BIT_THERMAL         1
`define BFO_BIT_OVERCURRENT     2
`define BFO_BIT_OVERVOLTAGE     3

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define BFO_RST_DIRECT_FORCE    6'h00
`define BFO_RST_STRING_ENABLE   6'h3f
`define BFO_NUM_STRINGS         6

`endif

/* bfo_sync2.v */
// Two-stage synchroniser for asynchronous analog monitor levels
`timescale 1ns/1ns
module bfo_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         CLK_SYS,
   input  wire         SRST,
   // Level in and out
   input  wire [W-1:0] D,
   output wire [W-1:0] Q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= D;
         sync_ff <= meta_ff;
      end
   end

   assign Q = sync_ff;
endmodule
